// ==== verilog/pwm_mod_ctrl.sv ====
// Pulse width modulation controller with a classic Wishbone slave.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pwm_mod_ctrl
  import pwm_pkg::*;
#(
  parameter int ARB_AW = 12
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // External modulating input
  input  wire logic signed [15:0] ext_mod_i,
  // Waveform and mode state
  output logic                    pulse_o,
  output logic                    pwm_on_o,
  output logic                    sweep_on_o,
  output logic                    burst_on_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [TIME_W-1:0] tmin(
    input logic [TIME_W-1:0] x,
    input logic [TIME_W-1:0] y);
    return (x < y) ? x : y;
  endfunction

  // Saturating subtraction keeps every limit at or above zero.
  function automatic logic [TIME_W-1:0] tsub(
    input logic [TIME_W-1:0] x,
    input logic [TIME_W-1:0] y);
    return (x > y) ? x - y : '0;
  endfunction

  function automatic logic [TIME_W-1:0] pct2ns(
    input logic [TIME_W-1:0] p,
    input logic [13:0]       d);
    logic [79:0] pr;
    pr = 80'(p) * 80'(d) * 80'(DUTY_RCP);
    return pr[DUTY_SH +: TIME_W];
  endfunction

  // Parabolic sine is cheap and accurate to a few percent.
  function automatic logic signed [15:0] shape_val(
    input pwm_shape_e         s,
    input logic [15:0]        ph,
    input logic signed [15:0] nz,
    input logic signed [15:0] av);
    logic [29:0] sq;
    logic [15:0] u;
    logic [15:0] pk;
    sq = 30'(ph[14:0]) * 30'(15'h7FFF - ph[14:0]);
    pk = (sq[29:13] > 17'h7FFF) ? 16'h7FFF : sq[28:13];
    u  = ph[15] ? ~ph : ph;
    unique case (s)
      SH_SINE:   return ph[15] ? -$signed(pk) : $signed(pk);
      SH_SQUARE: return ph[15] ? 16'sh8001 : 16'sh7FFF;
      SH_RAMP:   return $signed({~ph[15], ph[14:0]});
      SH_NRAMP:  return $signed({ph[15], ~ph[14:0]});
      SH_TRI:    return $signed({~u[14], u[13:0], 1'b0});
      SH_NOISE:  return nz;
      SH_ARB:    return av;
      default:   return 16'sh0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  pwm_ctrl_s           ctrl_r;
  logic [TIME_W-1:0]   period_r;
  logic [TIME_W-1:0]   width_r;
  logic [TIME_W-1:0]   wdev_r;
  logic [TIME_W-1:0]   edge_r;
  logic [HI_W-1:0]     time_hi_r;
  logic [13:0]         duty_r;
  logic [13:0]         dcdev_r;
  logic [24:0]         mfreq_r;
  logic                err_r;
  logic                ack_r;
  logic [31:0]         rdat_r;
  logic [31:0]         arb_len_r;
  logic [31:0]         arb_acc_r;
  logic [12:0]         arb_cnt_r;
  logic signed [15:0]  arb_mem [0:(1<<ARB_AW)-1];
  logic [47:0]         phase_r;
  logic [15:0]         lfsr_r;
  logic [TIME_W-1:0]   cnt_r;
  logic [TIME_W-1:0]   wcur_r;
  logic signed [15:0]  mval_r;
  logic                pulse_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire               req   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire               wr    = req & wb_we_i & (wb_sel_i == 4'hF);
  wire               rd    = req & ~wb_we_i;
  wire [7:0]         adr   = {wb_adr_i[7:2], 2'b00};
  wire [TIME_W-1:0]  t_new = {time_hi_r, wb_dat_i};
  wire [13:0]        d_new = wb_dat_i[13:0];
  wire               d_ok  = (wb_dat_i[31:14] == '0) &
                             (d_new <= DUTY_FULL);

  wire wr_ctrl   = wr & (adr == A_CTRL);
  wire wr_stat   = wr & (adr == A_STATUS);
  wire wr_period = wr & (adr == A_PERIOD);
  wire wr_width  = wr & (adr == A_WIDTH);
  wire wr_wdev   = wr & (adr == A_WDEV);
  wire wr_edge   = wr & (adr == A_EDGE);
  wire wr_thi    = wr & (adr == A_TIMEHI);
  wire wr_duty   = wr & (adr == A_DUTY);
  wire wr_dcdev  = wr & (adr == A_DCDEV);
  wire wr_mfreq  = wr & (adr == A_MFREQ);
  wire wr_arblen = wr & (adr == A_ARBLEN);
  wire wr_arbdat = wr & (adr == A_ARBDAT);

  // ----------------------------------------------------------------
  // Mode control checks
  // ----------------------------------------------------------------
  pwm_ctrl_s ctrl_in;
  pwm_ctrl_s ctrl_fix;
  assign ctrl_in = pwm_ctrl_s'(wb_dat_i);

  wire sweep_turn_on = ctrl_in.sweep_en & ~ctrl_r.sweep_en;

  always_comb begin
    ctrl_fix      = ctrl_in;
    ctrl_fix.rsvd = '0;
    if (sweep_turn_on) begin
      ctrl_fix.burst_en = 1'b0;
      ctrl_fix.pwm_en   = 1'b0;
    end
  end

  wire code_bad  = (ctrl_in.shape > SH_ARB) |
                   (ctrl_in.carrier > FN_ARB) |
                   (ctrl_in.mtype > MT_FSK);
  wire no_sweep  = (ctrl_fix.carrier == FN_PULSE) |
                   (ctrl_fix.carrier == FN_NOISE) |
                   (ctrl_fix.carrier == FN_DC);
  wire sweep_bad = ctrl_fix.sweep_en &
                   (no_sweep | ctrl_fix.burst_en);
  wire type_bad  = (ctrl_fix.carrier == FN_PULSE) &
                   (ctrl_fix.mtype != MT_PWM);
  wire pwm_bad   = ctrl_fix.pwm_en &
                   ((ctrl_fix.carrier != FN_PULSE) |
                    ctrl_fix.sweep_en | ctrl_fix.burst_en);
  wire ctrl_bad  = code_bad | sweep_bad | type_bad | pwm_bad;

  // ----------------------------------------------------------------
  // Deviation limits
  // ----------------------------------------------------------------
  wire [TIME_W-1:0] wmin =
    (period_r <= P_10S)   ? WMIN_A :
    (period_r <= P_100S)  ? WMIN_B :
    (period_r <= P_1000S) ? WMIN_C : WMIN_D;

  wire [57:0]       e_prod = 58'(edge_r) * 58'(EDGE_MUL);
  wire [TIME_W-1:0] e16    = e_prod[EDGE_SH +: TIME_W];

  // Duty settings are turned into ns so one set of limits serves
  // both the width and the duty cycle view.
  wire [TIME_W-1:0] w_nom  = ctrl_r.duty_mode ?
                             pct2ns(period_r, duty_r) : width_r;
  wire [TIME_W-1:0] pw     = tsub(period_r, w_nom);
  wire [TIME_W-1:0] lim_mw = tmin(tsub(w_nom, wmin),
                                  tsub(pw, wmin));
  wire [TIME_W-1:0] lim_e  = tmin(tsub(w_nom, e16),
                                  tsub(pw, e16));
  wire [TIME_W-1:0] lim    = tmin(w_nom,
                                  tmin(lim_mw, lim_e));

  wire [TIME_W-1:0] dc_new = pct2ns(period_r, d_new);
  wire [TIME_W-1:0] dev_sel = ctrl_r.duty_mode ?
                              pct2ns(period_r, dcdev_r) : wdev_r;
  // Later period or width changes may shrink the limit, so the
  // stored deviation is clamped again at the point of use.
  wire [TIME_W-1:0] dev_use = tmin(dev_sel, lim);

  wire per_ok   = (t_new >= PERIOD_MIN) &
                  (t_new <= PERIOD_MAX);
  wire width_ok = (t_new < period_r);
  wire wdev_ok  = (t_new <= WDEV_MAX) & (t_new <= lim);
  wire dcdev_ok = d_ok & (dc_new <= lim);
  wire mfreq_ok = (wb_dat_i[31:25] == '0) &
                  (wb_dat_i[24:0] >= MFREQ_MIN) &
                  (wb_dat_i[24:0] <= MFREQ_MAX);

  wire rejected = (wr_ctrl & ctrl_bad) |
                  (wr_period & ~per_ok) |
                  (wr_width & ~width_ok) |
                  (wr_wdev & ~wdev_ok) |
                  (wr_duty & ~d_ok) |
                  (wr_dcdev & ~dcdev_ok) |
                  (wr_mfreq & ~mfreq_ok);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r   <= '0;
      period_r <= PERIOD_RST;
      width_r  <= WIDTH_RST;
      wdev_r   <= WDEV_RST;
      edge_r   <= EDGE_RST;
      duty_r   <= DUTY_RST;
      dcdev_r  <= DCDEV_RST;
      mfreq_r  <= MFREQ_RST;
    end else begin
      if (wr_ctrl & ~ctrl_bad)  ctrl_r   <= ctrl_fix;
      if (wr_period & per_ok)   period_r <= t_new;
      if (wr_width & width_ok)  width_r  <= t_new;
      if (wr_wdev & wdev_ok)    wdev_r   <= t_new;
      if (wr_edge)              edge_r   <= t_new;
      if (wr_duty & d_ok)       duty_r   <= d_new;
      if (wr_dcdev & dcdev_ok)  dcdev_r  <= d_new;
      if (wr_mfreq & mfreq_ok)  mfreq_r  <= wb_dat_i[24:0];
    end
  end

  // Reading a time register parks its upper bits for the next read.
  wire [HI_W-1:0] hi_rd =
    (adr == A_PERIOD) ? period_r[TIME_W-1:32] :
    (adr == A_WIDTH)  ? width_r[TIME_W-1:32]  :
    (adr == A_WDEV)   ? wdev_r[TIME_W-1:32]   :
    (adr == A_EDGE)   ? edge_r[TIME_W-1:32]   : time_hi_r;

  // A set in the same cycle as a clear wins.
  wire err_nxt = rejected |
                 (err_r & ~(wr_stat & wb_dat_i[ST_ERR]));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_hi_r <= '0;
      err_r     <= 1'b0;
    end else begin
      err_r <= err_nxt;
      if (wr_thi)  time_hi_r <= wb_dat_i[HI_W-1:0];
      else if (rd) time_hi_r <= hi_rd;
    end
  end

  // ----------------------------------------------------------------
  // Arbitrary modulating shape store
  // ----------------------------------------------------------------
  // Long shapes are thinned evenly as they arrive, so no full
  // length copy has to be held anywhere.
  wire [31:0] acc_add = arb_acc_r + 32'(ARB_PTS);
  wire        arb_big = arb_len_r > 32'(ARB_PTS);
  wire        arb_keep = (~arb_big | (acc_add >= arb_len_r)) &
                         (arb_cnt_r < ARB_PTS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arb_len_r <= '0;
      arb_acc_r <= '0;
      arb_cnt_r <= '0;
    end else if (wr_arblen) begin
      arb_len_r <= wb_dat_i;
      arb_acc_r <= '0;
      arb_cnt_r <= '0;
    end else if (wr_arbdat) begin
      if (arb_big)
        arb_acc_r <= (acc_add >= arb_len_r) ?
                     acc_add - arb_len_r : acc_add;
      if (arb_keep)
        arb_cnt_r <= arb_cnt_r + 13'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_arbdat & arb_keep)
      arb_mem[arb_cnt_r[ARB_AW-1:0]] <= $signed(wb_dat_i[15:0]);
  end

  // ----------------------------------------------------------------
  // Internal modulating source
  // ----------------------------------------------------------------
  wire [47:0] step_p = 48'(mfreq_r) * 48'(FSTEP_MUL);
  wire [47:0] step   = step_p >> FSTEP_SH;
  wire [15:0] ph     = phase_r[47:32];
  wire [28:0] a_idx  = 29'(ph) * 29'(arb_cnt_r);
  wire signed [15:0] arb_v = (arb_cnt_r == '0) ? 16'sh0000 :
                             arb_mem[a_idx[16 +: ARB_AW]];
  wire signed [15:0] int_v = shape_val(ctrl_r.shape, ph,
                                       $signed(lfsr_r), arb_v);
  wire signed [15:0] ext_v = (ext_mod_i == 16'sh8000) ?
                             16'sh8001 : ext_mod_i;
  wire signed [15:0] mval  = ctrl_r.ext_src ? ext_v : int_v;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= '0;
      lfsr_r  <= LFSR_SEED;
    end else begin
      phase_r <= phase_r + step;
      lfsr_r  <= {lfsr_r[14:0],
                  lfsr_r[15] ^ lfsr_r[14] ^ lfsr_r[12] ^ lfsr_r[3]};
    end
  end

  // ----------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------
  wire signed [59:0] m_prod = $signed({1'b0, dev_use}) *
                              $signed(mval);
  wire signed [59:0] w_sum  = $signed({18'h0, w_nom}) +
                              (m_prod >>> 15);
  wire [TIME_W-1:0]  w_mod  = w_sum[TIME_W-1:0];
  wire [TIME_W-1:0]  cnt_n  = cnt_r + CLK_NS;
  wire               wrap   = cnt_n >= period_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r   <= '0;
      wcur_r  <= WIDTH_RST;
      mval_r  <= '0;
      pulse_r <= 1'b0;
    end else begin
      cnt_r   <= wrap ? '0 : cnt_n;
      pulse_r <= cnt_r < wcur_r;
      if (wrap) begin
        wcur_r <= ctrl_r.pwm_en ? w_mod : w_nom;
        mval_r <= mval;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus read and answer
  // ----------------------------------------------------------------
  wire [31:0] stat_w = {27'h0, ctrl_r.ext_src, ctrl_r.sweep_en,
                        pulse_r, err_r, ctrl_r.pwm_en};
  wire [31:0] rd_d =
    (adr == A_CTRL)   ? 32'(ctrl_r)           :
    (adr == A_STATUS) ? stat_w                :
    (adr == A_PERIOD) ? period_r[31:0]        :
    (adr == A_WIDTH)  ? width_r[31:0]         :
    (adr == A_WDEV)   ? wdev_r[31:0]          :
    (adr == A_EDGE)   ? edge_r[31:0]          :
    (adr == A_TIMEHI) ? 32'(time_hi_r)        :
    (adr == A_DUTY)   ? 32'(duty_r)           :
    (adr == A_DCDEV)  ? 32'(dcdev_r)          :
    (adr == A_MFREQ)  ? 32'(mfreq_r)          :
    (adr == A_ARBLEN) ? arb_len_r             :
    (adr == A_ARBDAT) ? 32'(arb_cnt_r)        :
    (adr == A_MODVAL) ? 32'($unsigned(mval_r)) : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r  <= req;
      rdat_r <= rd ? rd_d : '0;
    end
  end

  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = rdat_r;
  assign pulse_o    = pulse_r;
  assign pwm_on_o   = ctrl_r.pwm_en;
  assign sweep_on_o = ctrl_r.sweep_en;
  assign burst_on_o = ctrl_r.burst_en;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pwm_carrier: assert property (
    ctrl_r.pwm_en |-> ctrl_r.carrier == FN_PULSE &&
                      ctrl_r.mtype == MT_PWM)
    else $error("PWM active without pulse carrier");

  a_pwm_exclusive: assert property (
    ctrl_r.pwm_en |-> !ctrl_r.sweep_en && !ctrl_r.burst_en)
    else $error("PWM active with sweep or burst");

  a_period_range: assert property (
    period_r >= PERIOD_MIN && period_r <= PERIOD_MAX)
    else $error("Period out of range");

  a_arb_points: assert property (
    wr_arbdat && arb_cnt_r == ARB_PTS |=> arb_cnt_r == ARB_PTS)
    else $error("Arbitrary store grew past its limit");

  a_mfreq_range: assert property (
    mfreq_r >= MFREQ_MIN && mfreq_r <= MFREQ_MAX)
    else $error("Modulating frequency out of range");

  a_dev_bound: assert property (
    wrap && ctrl_r.pwm_en |=> wcur_r + $past(lim) >= $past(w_nom) &&
                              wcur_r <= $past(w_nom) + $past(lim))
    else $error("Modulated width beyond its deviation limit");

  a_sweep_clears: assert property (
    wr_ctrl && !ctrl_bad && sweep_turn_on
    |=> ctrl_r.sweep_en && !ctrl_r.pwm_en && !ctrl_r.burst_en)
    else $error("Sweep did not clear burst and PWM");

  a_sweep_carrier: assert property (
    ctrl_r.sweep_en |-> !(ctrl_r.carrier inside
                          {FN_PULSE, FN_NOISE, FN_DC}))
    else $error("Sweep with illegal carrier");

  a_width_plain: assert property (
    wrap && !ctrl_r.pwm_en |=> wcur_r == $past(w_nom))
    else $error("Unmodulated width not nominal");

  a_ext_scale: assert property (
    wrap && ctrl_r.pwm_en && ctrl_r.ext_src && ext_mod_i == 16'sh0
    |=> wcur_r == $past(w_nom))
    else $error("Zero external input moved the width");

  a_err_sticky: assert property (
    rejected |=> err_r [*2])
    else $error("Rejected write lost its error flag");

  c_pwm_running: cover property (
    ctrl_r.pwm_en && wrap ##1 wcur_r != $past(w_nom));
  c_sweep_on: cover property (
    wr_ctrl && sweep_turn_on && !ctrl_bad);
  c_rejected: cover property (wr && rejected);
  c_arb_thin: cover property (wr_arbdat && arb_big && !arb_keep);

endmodule

`default_nettype wire

// ==== verilog/pwm_pkg.sv ====
// Package: constants and types of the pulse width modulation controller.
package pwm_pkg;

  // ----------------------------------------------------------------
  // Widths and register offsets
  // ----------------------------------------------------------------
  localparam int TIME_W = 42;
  localparam int HI_W   = TIME_W - 32;

  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_PERIOD = 8'h08;
  localparam logic [7:0] A_WIDTH  = 8'h0C;
  localparam logic [7:0] A_WDEV   = 8'h10;
  localparam logic [7:0] A_EDGE   = 8'h14;
  localparam logic [7:0] A_TIMEHI = 8'h18;
  localparam logic [7:0] A_DUTY   = 8'h1C;
  localparam logic [7:0] A_DCDEV  = 8'h20;
  localparam logic [7:0] A_MFREQ  = 8'h24;
  localparam logic [7:0] A_ARBLEN = 8'h28;
  localparam logic [7:0] A_ARBDAT = 8'h2C;
  localparam logic [7:0] A_MODVAL = 8'h30;

  localparam int ST_PWM   = 0;
  localparam int ST_ERR   = 1;
  localparam int ST_PULSE = 2;
  localparam int ST_SWEEP = 3;
  localparam int ST_EXT   = 4;

  // ----------------------------------------------------------------
  // Reset values and limits, times in ns, duty in 0.01 %
  // ----------------------------------------------------------------
  localparam logic [TIME_W-1:0] PERIOD_RST = 42'hF4240;
  localparam logic [TIME_W-1:0] PERIOD_MIN = 42'hC8;
  localparam logic [TIME_W-1:0] PERIOD_MAX = 42'h1D1A94A2000;
  localparam logic [TIME_W-1:0] WIDTH_RST  = 42'h186A0;
  localparam logic [TIME_W-1:0] WDEV_RST   = 42'h2710;
  localparam logic [TIME_W-1:0] WDEV_MAX   = 42'hE8D4A51000;
  localparam logic [TIME_W-1:0] EDGE_RST   = 42'h5;
  localparam logic [TIME_W-1:0] P_10S      = 42'h2540BE400;
  localparam logic [TIME_W-1:0] P_100S     = 42'h174876E800;
  localparam logic [TIME_W-1:0] P_1000S    = 42'hE8D4A51000;
  localparam logic [TIME_W-1:0] WMIN_A     = 42'h14;
  localparam logic [TIME_W-1:0] WMIN_B     = 42'hC8;
  localparam logic [TIME_W-1:0] WMIN_C     = 42'h7D0;
  localparam logic [TIME_W-1:0] WMIN_D     = 42'h4E20;
  localparam logic [13:0]       DUTY_FULL  = 14'h2710;
  localparam logic [13:0]       DUTY_RST   = 14'h3E8;
  localparam logic [13:0]       DCDEV_RST  = 14'h64;
  localparam logic [24:0]       MFREQ_MIN  = 25'h2;
  localparam logic [24:0]       MFREQ_MAX  = 25'h1312D00;
  localparam logic [24:0]       MFREQ_RST  = 25'h2710;
  localparam logic [12:0]       ARB_PTS    = 13'h1000;

  // ----------------------------------------------------------------
  // Arithmetic scale factors and clock
  // ----------------------------------------------------------------
  localparam int               CLK_MHZ    = 125;
  localparam logic [TIME_W-1:0] CLK_NS    = TIME_W'(1000 / CLK_MHZ);
  localparam logic [15:0]      EDGE_MUL   = 16'h3334;
  localparam int               EDGE_SH    = 13;
  localparam logic [16:0]      DUTY_RCP   = 17'h1A36F;
  localparam int               DUTY_SH    = 30;
  localparam logic [15:0]      FSTEP_MUL  = 16'h8CBD;
  localparam int               FSTEP_SH   = 4;
  localparam logic [15:0]      LFSR_SEED  = 16'hACE1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SH_SINE, SH_SQUARE, SH_RAMP, SH_NRAMP, SH_TRI, SH_NOISE, SH_ARB
  } pwm_shape_e;

  typedef enum logic [2:0] {
    FN_SINE, FN_SQUARE, FN_RAMP, FN_PULSE, FN_NOISE, FN_DC, FN_ARB
  } pwm_func_e;

  typedef enum logic [2:0] {
    MT_PWM, MT_AM, MT_FM, MT_PM, MT_FSK
  } pwm_mtype_e;

  typedef struct packed {
    logic [17:0] rsvd;
    pwm_func_e   carrier;
    pwm_mtype_e  mtype;
    pwm_shape_e  shape;
    logic        burst_en;
    logic        sweep_en;
    logic        duty_mode;
    logic        ext_src;
    logic        pwm_en;
  } pwm_ctrl_s;

endpackage

// ==== bench/pwm_ext_src.sv ====
// Model of the external bipolar modulating source.
`timescale 1ns/1ps
`default_nettype none
module pwm_ext_src (
  // Clock and requested level
  input  wire logic               clk_i,
  input  wire logic signed [15:0] lvl_i,
  // Modulating signal
  output var logic signed [15:0]  ext_mod_o
);
  // Full-scale codes stand for the plus and minus five volt extremes.
  always_ff @(posedge clk_i) ext_mod_o <= lvl_i;
endmodule
`default_nettype wire

// ==== bench/pwm_mod_ctrl_tb_top.sv ====
// Self-checking testbench of the pulse width modulation controller.
`timescale 1ns/1ps
`default_nettype none
module pwm_mod_ctrl_tb_top
  import pwm_pkg::*;
;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [3:0]         sel = 4'h0;
  logic [31:0]        dat = 32'h0, q, rdat;
  logic               ack, pulse, pwm_on, sweep_on, burst_on;
  logic signed [15:0] lvl = 16'h0000, ext;
  int                 fail_count = 0, checked = 0, seed = 32662, m;
  always #4 clk_i = ~clk_i;
  pwm_mod_ctrl pwm_mod_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_mod_i(ext), .pulse_o(pulse), .pwm_on_o(pwm_on),
    .sweep_on_o(sweep_on), .burst_on_o(burst_on));
  pwm_ext_src pwm_ext_src_inst (.clk_i(clk_i), .lvl_i(lvl), .ext_mod_o(ext));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // The request stands until ack is seen or 20 cycles pass, so slow answers are tolerated.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    if (n >= 20) chk(32'h0, 32'h1);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // A refused value leaves the error flag set; it is cleared afterwards.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    bus(1'b1, A_TIMEHI, 32'h0, q);
    bus(1'b1, a, d, q);
    rd(A_TIMEHI, 32'h0);
    bus(1'b0, A_STATUS, 32'h0, q);
    chk({31'h0, q[1]}, {31'h0, e});
    bus(1'b1, A_STATUS, 32'h2, q);
  endtask
  function automatic int exp_hi(input int w, input int d, input int v);
    return (w + ((d * v) >>> 15) + 7) / 8;
  endfunction
  task automatic meas(input int e);
    int n;
    n = 0;
    do @(posedge clk_i); while (pulse !== 1'b0);
    do @(posedge clk_i); while (pulse !== 1'b1);
    while (pulse === 1'b1 && n < 200) begin
      n++;
      @(posedge clk_i);
    end
    chk(32'(n), 32'(e));
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_CTRL, 32'h0);
    rd(A_PERIOD, PERIOD_RST[31:0]);
    rd(A_WDEV, WDEV_RST[31:0]);
    rd(A_DCDEV, 32'(DCDEV_RST));
    rd(A_MFREQ, 32'(MFREQ_RST));
    rd(8'h3C, 32'h0);
    $display("test reset done");
    wr(A_CTRL, 32'h1, 1'b1);
    wr(A_CTRL, 32'h1900, 1'b1);
    wr(A_CTRL, 32'h1811, 1'b1);
    wr(A_CTRL, 32'h1808, 1'b1);
    wr(A_CTRL, 32'h10, 1'b0);
    wr(A_CTRL, 32'h18, 1'b0);
    chk({30'h0, sweep_on, burst_on}, 32'h2);
    for (int s = 0; s < 8; s++)
      wr(A_CTRL, 32'h1800 | 32'(s << 5), s == 7);
    $display("test modes done");
    wr(A_MFREQ, 32'h1, 1'b1);
    wr(A_MFREQ, 32'h1312D00, 1'b0);
    wr(A_MFREQ, 32'h1312D01, 1'b1);
    wr(A_DCDEV, 32'h2711, 1'b1);
    wr(A_WIDTH, 32'h190, 1'b0);
    wr(A_PERIOD, 32'hC7, 1'b1);
    wr(A_PERIOD, 32'h3E8, 1'b0);
    wr(A_WDEV, 32'h17D, 1'b1);
    wr(A_WDEV, 32'h17C, 1'b0);
    wr(A_EDGE, 32'h32, 1'b0);
    wr(A_WDEV, 32'h141, 1'b1);
    wr(A_WDEV, 32'h140, 1'b0);
    $display("test limits done");
    wr(A_CTRL, 32'h1803, 1'b0);
    chk({31'h0, pwm_on}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? -32767 : (i == 1) ? 32767 : $random(seed) % 32768;
      lvl <= (i == 0) ? 16'sh8000 : 16'(m);
      repeat (300) @(posedge clk_i);
      meas(exp_hi(400, 320, m));
      bus(1'b0, A_MODVAL, 32'h0, q);
      chk({16'h0, q[15:0]}, {16'h0, 16'(m)});
    end
    wr(A_DUTY, 32'h1388, 1'b0);
    wr(A_CTRL, 32'h1806, 1'b0);
    wr(A_DCDEV, 32'h1072, 1'b1);
    wr(A_DCDEV, 32'h7D0, 1'b0);
    wr(A_CTRL, 32'h1807, 1'b0);
    lvl <= 16'sh7FFF;
    repeat (300) @(posedge clk_i);
    meas(exp_hi(500, 200, 32767));
    $display("test external done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
